// *** nvm_pkg.sv ***
// Shared constants and types for the flash self-programming controller.
package nvm_pkg;
	// Pointer and data widths.
	localparam int PTR_W = 22;
	localparam int DATA_W = 8;
	localparam int BLK_LSB = 6;
	// Holding block size: 64 bytes, 6 selecting bits.
	localparam int HOLD_BYTES = 64;
	localparam int HOLD_SEL_W = 6;
	localparam int ERASE_BYTES = 64;
	// Unlock keys.
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic [7:0] HOLD_RESET = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// Control byte field positions.
	localparam int CTL_PGM_SEL = 7;
	localparam int CTL_CFG_SEL = 6;
	localparam int CTL_ERASE = 4;
	localparam int CTL_ERR = 3;
	localparam int CTL_PROGRAM_ENABLE_BIT = 2;
	localparam int CTL_START = 1;
	localparam logic [7:0] CTL_RESET = 8'h00;
	// Cycle time: 2 ms at 100 MHz.
	localparam int CLK_MHZ = 100;
	localparam int CYCLE_US = 2000;
	localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
	localparam int TMR_W = 18;
	// Operation codes presented by the core.
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_FETCH = 3'h1,
		OP_STORE = 3'h2,
		OP_CTL_WR = 3'h3,
		OP_KEY_WR = 3'h4
	} op_e;
	// Pointer adjust before or after a fetch or store.
	typedef enum logic [1:0] {
		ADJ_NONE = 2'h0,
		ADJ_POST_INC = 2'h1,
		ADJ_POST_DEC = 2'h2,
		ADJ_PRE_INC = 2'h3
	} adj_e;
endpackage

// *** nvm_if.sv ***
// Link between the processor core and the flash controller.
`timescale 1ns/1ps
`default_nettype none
interface nvm_if;
	logic [2:0] op;
	logic [1:0] adj;
	logic [7:0] wdata;
	logic [21:0] ptr_load;
	logic ptr_load_en;
	logic [21:0] table_pointer;
	logic [7:0] table_latch;
	logic [7:0] nvm_control_reg;
	logic stall;
	logic nvm_done_flag;
	logic done_clr;
	modport device (
		input op, adj, wdata, ptr_load, ptr_load_en, done_clr,
		output table_pointer, table_latch, nvm_control_reg, stall,
		output nvm_done_flag
	);
	modport core (
		output op, adj, wdata, ptr_load, ptr_load_en, done_clr,
		input table_pointer, table_latch, nvm_control_reg, stall,
		input nvm_done_flag
	);
endinterface
`default_nettype wire

// *** nvm_array.sv ***
// Flash array model store: byte read, block erase, clear-only program.
`timescale 1ns/1ps
`default_nettype none
module nvm_array (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Read port.
	input wire logic [21:0] rd_addr,
	output logic [7:0] rd_data,
	// Erase and program commands.
	input wire logic erase_go,
	input wire logic prog_go,
	input wire logic [21:0] op_addr,
	input wire logic [7:0] hold [64]
);
	localparam int DEPTH = 4096;
	logic [7:0] mem [DEPTH];
	logic [11:0] blk_base;
	logic [11:0] ra;

	assign blk_base = {op_addr[11:nvm_pkg::BLK_LSB], 6'h00};
	assign ra = rd_addr[11:0];
	assign rd_data = mem[ra];

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < nvm_pkg::ERASE_BYTES; i++) begin
			if (rst) begin
				mem[blk_base + 12'(i)] <= mem[blk_base + 12'(i)];
			end else if (erase_go) begin
				// Whole block only; low pointer bits are ignored.
				mem[blk_base + 12'(i)] <= nvm_pkg::ERASED_BYTE; // [R4] [R5]
			end else if (prog_go) begin
				// Programming can only clear bits. FFh leaves a byte alone.
				mem[blk_base + 12'(i)] <= mem[blk_base + 12'(i)] & hold[i]; // [R13] [R12]
			end
		end
	end
endmodule
`default_nettype wire

// *** nvm_device.sv ***
// Flash self-programming controller, device end.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Table fetch returns exactly one byte
// [R2] Fetch copies addressed byte; pointer may adjust
// [R3] Pointer bit zero picks word half
// [R4] Erase always clears a 64-byte block
// [R5] Erase block from pointer bits 21:6; the array model decodes bits 11:6 only
// [R6] Core configures control bits before erase
// [R7] Keys 55h, AAh, then start bit
// [R8] Core stalls until timer ends erase
// [R9] Erase stall lasts about 2 ms
// [R10] Program whole block only, never single bytes
// [R11] Stores fill holding registers only
// [R12] Holding bytes reset to FFh; FFh untouched
// [R13] Programming only clears bits
// [R14] Core configures control bits before program
// [R15] Program stall lasts about 2 ms
// [R16] Core keeps pointer inside held range; the core model loads any pointer unchecked
// [R17] Core follows read-erase-program-verify flow
// [R18] Core masks interrupts around unlock sequence
// [R19] Start bit set-only; hardware clears it
// [R20] Done flag sticky until firmware clears
// [R21] Erase select clears after erase
// [R22] Low pointer bits pick holding register
module nvm_device #(
	// Length of an erase or program cycle in clocks; a bench may shorten it.
	parameter int TIMER_CLKS = nvm_pkg::CYCLE_CLKS
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Core link.
	nvm_if.device bus
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ERASE = 3'b010,
		ST_PROG = 3'b100
	} state_e;

	typedef enum logic [2:0] {
		KEY_NONE = 3'b001,
		KEY_HALF = 3'b010,
		KEY_ARMED = 3'b100
	} key_e;

	typedef struct packed {
		state_e st;
		key_e key;
		logic [21:0] ptr;
		logic [7:0] latch;
		logic [7:0] ctl;
		logic [17:0] tmr;
		logic done;
	} state_s;

	state_s s_reg;
	state_s s_next;
	logic [7:0] hold_reg [64];
	logic [21:0] rd_addr;
	logic [7:0] rd_data;
	logic erase_go;
	logic prog_go;

	// Pointer used for the fetch, honouring pre-increment.
	function automatic logic [21:0] adj_ptr(input logic [21:0] p,
			input logic [1:0] a, input logic pre);
		logic [21:0] r;
		r = p;
		if (pre && a == nvm_pkg::ADJ_PRE_INC) begin
			r = {p[21], p[20:0] + 21'h1};
		end else if (!pre && a == nvm_pkg::ADJ_POST_INC) begin
			r = {p[21], p[20:0] + 21'h1};
		end else if (!pre && a == nvm_pkg::ADJ_POST_DEC) begin
			r = {p[21], p[20:0] - 21'h1};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Array and holding registers.

	// Byte address: bit zero selects the half of the stored word.
	assign rd_addr = adj_ptr(s_reg.ptr, bus.adj, 1'b1); // [R3]

	nvm_array u_array (
		.clk_sys(clk_sys),
		.rst(rst),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.erase_go(erase_go),
		.prog_go(prog_go),
		.op_addr(s_reg.ptr),
		.hold(hold_reg)
	);

	// Launch the array action on the final timer tick.
	assign erase_go = s_reg.st == ST_ERASE && s_reg.tmr == 18'h1;
	assign prog_go = s_reg.st == ST_PROG && s_reg.tmr == 18'h1;

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < nvm_pkg::HOLD_BYTES; i++) begin
			if (rst || prog_go) begin
				hold_reg[i] <= nvm_pkg::HOLD_RESET; // [R12]
			end else if (s_reg.st == ST_IDLE && bus.op == nvm_pkg::OP_STORE
					&& rd_addr[nvm_pkg::HOLD_SEL_W-1:0] == 6'(i)) begin
				// The store carries the byte the core puts in the latch.
				// Only the low pointer bits address the bank.
				hold_reg[i] <= bus.wdata; // [R11] [R22]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_comb begin
		logic [7:0] w;
		logic go;
		w = bus.wdata;
		go = 1'b0;
		s_next = s_reg;
		if (bus.done_clr) begin
			s_next.done = 1'b0;
		end
		unique case (s_reg.st)
			ST_IDLE: begin
				if (bus.ptr_load_en) begin
					s_next.ptr = bus.ptr_load;
				end
				unique case (bus.op)
					nvm_pkg::OP_FETCH: begin
						// One byte per fetch. [R1]
						s_next.latch = rd_data; // [R2]
						s_next.ptr = adj_ptr(rd_addr, bus.adj, 1'b0); // [R2]
						s_next.key = KEY_NONE;
					end
					nvm_pkg::OP_STORE: begin
						s_next.latch = bus.wdata; // [R11]
						s_next.ptr = adj_ptr(rd_addr, bus.adj, 1'b0);
						s_next.key = KEY_NONE;
					end
					nvm_pkg::OP_KEY_WR: begin
						if (s_reg.key == KEY_NONE && w == nvm_pkg::KEY_FIRST) begin
							s_next.key = KEY_HALF; // [R7]
						end else if (s_reg.key == KEY_HALF
								&& w == nvm_pkg::KEY_SECOND) begin
							s_next.key = KEY_ARMED; // [R7]
						end else begin
							s_next.key = KEY_NONE;
						end
					end
					nvm_pkg::OP_CTL_WR: begin
						// Start is set-only and needs the armed keys. [R19]
						s_next.ctl = {w[7:6], 1'b0, w[4:2], s_reg.ctl[1], 1'b0};
						go = w[nvm_pkg::CTL_START] && s_reg.key == KEY_ARMED
							&& w[nvm_pkg::CTL_PROGRAM_ENABLE_BIT] && w[nvm_pkg::CTL_PGM_SEL]
							&& !w[nvm_pkg::CTL_CFG_SEL]; // [R7]
						s_next.ctl[nvm_pkg::CTL_ERR] = w[nvm_pkg::CTL_START]
							&& !go;
						s_next.key = KEY_NONE;
						if (go) begin
							s_next.ctl[nvm_pkg::CTL_START] = 1'b1;
							s_next.tmr = 18'(TIMER_CLKS); // [R9] [R15]
							// Whole block either way. [R10]
							s_next.st = w[nvm_pkg::CTL_ERASE] ? ST_ERASE : ST_PROG;
						end
					end
					default: begin
						// A stray operation between keys breaks the unlock.
						if (bus.op != nvm_pkg::OP_NONE) begin
							s_next.key = KEY_NONE;
						end
					end
				endcase
			end
			ST_ERASE, ST_PROG: begin
				// Core is stalled while the timer runs. [R8]
				s_next.tmr = s_reg.tmr - 18'h1;
				if (s_reg.tmr == 18'h1) begin
					s_next.st = ST_IDLE;
					s_next.ctl[nvm_pkg::CTL_START] = 1'b0; // [R19]
					s_next.ctl[nvm_pkg::CTL_ERASE] = 1'b0; // [R21]
					s_next.done = 1'b1; // [R20]
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '{st: ST_IDLE, key: KEY_NONE, ptr: 22'h0, latch: 8'h00,
				ctl: nvm_pkg::CTL_RESET, tmr: 18'h0, done: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign bus.table_pointer = s_reg.ptr;
	assign bus.table_latch = s_reg.latch;
	assign bus.nvm_control_reg = s_reg.ctl;
	assign bus.stall = s_reg.st != ST_IDLE; // [R8] [R15]
	assign bus.nvm_done_flag = s_reg.done;
endmodule
`default_nettype wire

// *** nvm_core.sv ***
// Processor-core end: turns user commands into link operations.
`timescale 1ns/1ps
`default_nettype none
module nvm_core (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// User commands.
	input wire logic [2:0] cmd_op,
	input wire logic [1:0] cmd_adj,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ptr_load,
	input wire logic [21:0] cmd_ptr,
	input wire logic cmd_done_clr,
	output logic cmd_ready,
	output logic [7:0] latch_data,
	output logic irq_masked,
	output logic done,
	// Device link.
	nvm_if.core bus
);
	typedef struct packed {
		logic [7:0] latch;
		logic mask;
	} state_s;

	state_s s_reg;
	state_s s_next;
	logic [2:0] op_q;

	// No new operation while the device stalls. [R8]
	assign cmd_ready = !bus.stall;
	assign op_q = cmd_ready ? cmd_op : nvm_pkg::OP_NONE;
	assign bus.op = op_q;
	assign bus.adj = cmd_adj;
	// Control writes always keep flash selected, config clear. [R6] [R14]
	assign bus.wdata = op_q == nvm_pkg::OP_CTL_WR ?
		(cmd_data | 8'h84) & 8'hbf : cmd_data;
	assign bus.ptr_load = cmd_ptr;
	assign bus.ptr_load_en = cmd_ready && cmd_ptr_load; // [R16] [R17]
	assign bus.done_clr = cmd_done_clr;

	always_comb begin
		s_next = s_reg;
		s_next.latch = bus.table_latch;
		// Interrupts masked from first key until the cycle starts. [R18]
		if (op_q == nvm_pkg::OP_KEY_WR) begin
			s_next.mask = 1'b1;
		end else if (bus.stall || op_q == nvm_pkg::OP_FETCH
				|| op_q == nvm_pkg::OP_STORE) begin
			s_next.mask = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '{latch: 8'h00, mask: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign latch_data = s_reg.latch;
	assign irq_masked = s_reg.mask;
	assign done = bus.nvm_done_flag;
endmodule
`default_nettype wire

// *** nvm_link_asserts.sv ***
// Concurrent checks on the link between core and flash controller.
`timescale 1ns/1ps
`default_nettype none
module nvm_link_asserts #(
	// Cycle length the watched controller was built with.
	parameter int TIMER_CLKS = nvm_pkg::CYCLE_CLKS
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Link signals.
	input wire logic [2:0] op,
	input wire logic [1:0] adj,
	input wire logic [7:0] wdata,
	input wire logic ptr_load_en,
	input wire logic done_clr,
	input wire logic [21:0] table_pointer,
	input wire logic [7:0] nvm_control_reg,
	input wire logic stall,
	input wire logic nvm_done_flag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////
	// The stall is far longer than any repetition count allows.
	int stall_cnt;
	always_ff @(posedge clk_sys) begin
		if (rst || !stall) begin
			stall_cnt <= 0;
		end else begin
			stall_cnt <= stall_cnt + 1;
		end
	end
	start_keys_a: assert property ($rose(stall) |->
		$past(op, 3) == nvm_pkg::OP_KEY_WR
		&& $past(wdata, 3) == nvm_pkg::KEY_FIRST
		&& $past(op, 2) == nvm_pkg::OP_KEY_WR
		&& $past(wdata, 2) == nvm_pkg::KEY_SECOND
		&& $past(op) == nvm_pkg::OP_CTL_WR)
		else $error("cycle began without keys");
	refused_start_a: assert property (op == nvm_pkg::OP_CTL_WR
		&& wdata[nvm_pkg::CTL_START] && !stall
		&& $past(op) != nvm_pkg::OP_KEY_WR
		|=> !stall && nvm_control_reg[nvm_pkg::CTL_ERR])
		else $error("unkeyed start was taken");
	stall_length_a: assert property ($fell(stall) |->
		stall_cnt == TIMER_CLKS)
		else $error("stall length wrong");
	start_shown_a: assert property ($rose(stall) |->
		nvm_control_reg[nvm_pkg::CTL_START])
		else $error("start bit not set in cycle");
	end_clears_a: assert property ($fell(stall) |->
		!nvm_control_reg[nvm_pkg::CTL_START]
		&& !nvm_control_reg[nvm_pkg::CTL_ERASE])
		else $error("start or erase bit left set");
	done_raise_a: assert property ($fell(stall) |-> nvm_done_flag)
		else $error("done flag not raised");
	done_sticky_a: assert property (nvm_done_flag && !done_clr |=>
		nvm_done_flag)
		else $error("done flag dropped");
	stall_hold_a: assert property (stall |=> $stable(table_pointer))
		else $error("pointer moved during stall");
	fetch_inc_a: assert property (op == nvm_pkg::OP_FETCH
		&& adj == nvm_pkg::ADJ_POST_INC && !stall && !ptr_load_en
		|=> table_pointer == $past(table_pointer) + 22'h1)
		else $error("post increment wrong");
	cover property ($rose(stall));
	cover property ($rose(stall) && nvm_control_reg[nvm_pkg::CTL_ERASE]);
	cover property (op == nvm_pkg::OP_CTL_WR && wdata[nvm_pkg::CTL_START]
		&& !stall);
	cover property (done_clr && nvm_done_flag);
endmodule
`default_nettype wire

// *** flash_self_program_ctrl_bench.sv ***
// Self-checking bench joining core and controller ends.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_ctrl_bench;
logic clk_sys = 1'b0;
logic rst = 1'b1;
logic [2:0] cmd_op = 3'h0;
logic [1:0] cmd_adj = 2'h0;
logic [7:0] cmd_data = 8'h00;
logic cmd_ptr_load = 1'b0;
logic [21:0] cmd_ptr = 22'h000000;
logic cmd_done_clr = 1'b0;
logic cmd_ready;
logic irq_masked;
logic done;
logic [7:0] latch_data;
int err_count = 0;
int cmp_count = 0;
int cyc = 0;
int n;
// The cycle timer is cut short here so that five cycles stay cheap.
localparam int SIM_CLKS = 500;
nvm_if link();
nvm_device #(.TIMER_CLKS(SIM_CLKS)) i_nvm_device (.clk_sys(clk_sys),
	.rst(rst), .bus(link));
nvm_core i_nvm_core (.clk_sys(clk_sys), .rst(rst), .cmd_op(cmd_op),
	.cmd_adj(cmd_adj), .cmd_data(cmd_data), .cmd_ptr_load(cmd_ptr_load),
	.cmd_ptr(cmd_ptr), .cmd_done_clr(cmd_done_clr), .cmd_ready(cmd_ready),
	.latch_data(latch_data), .irq_masked(irq_masked), .done(done),
	.bus(link));
nvm_link_asserts #(.TIMER_CLKS(SIM_CLKS)) i_nvm_link_asserts (
	.clk_sys(clk_sys), .rst(rst),
	.op(link.op), .adj(link.adj), .wdata(link.wdata),
	.ptr_load_en(link.ptr_load_en), .done_clr(link.done_clr),
	.table_pointer(link.table_pointer),
	.nvm_control_reg(link.nvm_control_reg), .stall(link.stall),
	.nvm_done_flag(link.nvm_done_flag));
////////////////////////////////////////////////////////////
initial forever #5 clk_sys = ~clk_sys;
// Four cycle lengths plus 2000 clocks set the ceiling, room for five timed cycles and the traffic.
always @(posedge clk_sys) begin
	cyc++;
	if (cyc == 4 * SIM_CLKS + 2000) begin
		err_count++;
		close_out();
	end
end
task close_out();
	if (err_count == 0 && cmp_count > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
task chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
	cmp_count++;
	if (seen !== exp) begin
		err_count++;
		$display("wrong value %s expected %h seen %h", what, exp, seen);
	end
endtask
// Requests are chained with no gap, since the keys must be adjacent.
task put(input logic [2:0] o, input logic [7:0] d, input logic [1:0] a);
	cmd_op = o;
	cmd_data = d;
	cmd_adj = a;
	@(posedge clk_sys);
	#1;
endtask
task idle(input int k);
	cmd_op = 3'h0;
	repeat (k) @(posedge clk_sys);
	#1;
endtask
task ld(input logic [21:0] p);
	cmd_ptr_load = 1'b1;
	cmd_ptr = p;
	@(posedge clk_sys);
	#1;
	cmd_ptr_load = 1'b0;
endtask
task rd(input logic [1:0] a, input logic [7:0] exp);
	put(3'h1, 8'h00, a);
	idle(3);
	chk("fetched byte", latch_data, exp);
endtask
task long_op(input logic [7:0] c);
	put(3'h3, c & 8'hfd, 2'h0);
	put(3'h4, 8'h55, 2'h0);
	put(3'h4, 8'haa, 2'h0);
	put(3'h3, c, 2'h0);
	idle(0);
	chk("masked", irq_masked, 1'b1);
	n = 0;
	while (!link.stall && n < 5) begin
		@(posedge clk_sys);
		#1;
		n++;
	end
	chk("stall", link.stall, 1'b1);
	chk("ready", cmd_ready, 1'b0);
	n = 0;
	while (link.stall && n < 2 * SIM_CLKS) begin
		@(posedge clk_sys);
		#1;
		n++;
	end
	chk("stall length", n[21:0], 22'(SIM_CLKS));
	chk("start and erase", link.nvm_control_reg[4:1] & 4'h9, 4'h0);
	chk("done", done, 1'b1);
	chk("unmasked", irq_masked, 1'b0);
	cmd_done_clr = 1'b1;
	idle(1);
	cmd_done_clr = 1'b0;
	idle(2);
	chk("done cleared", link.nvm_done_flag, 1'b0);
endtask
initial begin
	repeat (12) @(posedge clk_sys);
	#1;
	rst = 1'b0;
	chk("control", link.nvm_control_reg, 8'h00);
	put(3'h3, 8'h86, 2'h0);
	idle(3);
	chk("unkeyed stall", link.stall, 1'b0);
	chk("error bit", link.nvm_control_reg[3], 1'b1);
	// Low pointer bits are junk on purpose; only the block counts.
	ld(22'h00007f);
	long_op(8'h96);
	ld(22'h000040);
	repeat (4) rd(2'h1, 8'hff);
	chk("pointer", link.table_pointer, 22'h000044);
	ld(22'h00007f);
	rd(2'h0, 8'hff);
	ld(22'h000040);
	put(3'h2, 8'h12, 2'h1);
	put(3'h2, 8'h34, 2'h1);
	idle(1);
	ld(22'h0003c3);
	put(3'h2, 8'ha5, 2'h0);
	idle(1);
	ld(22'h000040);
	long_op(8'h86);
	ld(22'h000040);
	rd(2'h1, 8'h12);
	rd(2'h1, 8'h34);
	rd(2'h1, 8'hff);
	rd(2'h2, 8'ha5);
	chk("pointer", link.table_pointer, 22'h000042);
	ld(22'h000040);
	rd(2'h3, 8'h34);
	ld(22'h000044);
	rd(2'h0, 8'hff);
	// A second pass over a written byte may only clear bits.
	ld(22'h000040);
	put(3'h2, 8'h3f, 2'h0);
	idle(1);
	long_op(8'h86);
	rd(2'h0, 8'h12);
	// After erasing, an empty program pass must leave the block blank,
	// which fails if the holding bytes kept their last values.
	long_op(8'h96);
	long_op(8'h86);
	rd(2'h0, 8'hff);
	close_out();
end
endmodule
`default_nettype wire
